// ---- pkg/cas_pkg.sv ----
/*
  cas_pkg: shared constants and types for the abcd signaling controller.
  assumes a 25 MHz system clock and a single synchronous reset.
*/
package cas_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned DISC_MS_MAX = 4000;
  localparam int unsigned GUARD_MS_MAX = 2000;
  localparam logic [11:0] DISC_MS_RST = 12'h0_3E8;
  localparam logic [11:0] GUARD_MS_RST = 12'h0_000;
  localparam logic [14:0] MS_LAST = 15'(MS_CYCLES - 1);

  // code table slot indices
  localparam logic [3:0] C_IDLE_TX = 4'h0;
  localparam logic [3:0] C_IDLE_RX = 4'h1;
  localparam logic [3:0] C_BLOCK_RX = 4'h2;
  localparam logic [3:0] C_RING_ON_TX = 4'h3;
  localparam logic [3:0] C_RING_OFF_TX = 4'h4;
  localparam logic [3:0] C_IN_OFFHK_RX = 4'h5;
  localparam logic [3:0] C_IN_CONN_TX = 4'h6;
  localparam logic [3:0] C_IN_FDISC_TX = 4'h7;
  localparam logic [3:0] C_IN_CDISC_RX = 4'h8;
  localparam logic [3:0] C_SEIZE_RX = 4'h9;
  localparam logic [3:0] C_SEIZE_ACK_TX = 4'hA;
  localparam logic [3:0] C_DIAL_MAKE_RX = 4'hB;
  localparam logic [3:0] C_DIAL_BRK_RX = 4'hC;
  localparam logic [3:0] C_ANSWERED_TX = 4'hD;
  localparam logic [3:0] C_OUT_CDISC_RX = 4'hE;
  localparam logic [3:0] C_OUT_FDISC_TX = 4'hF;
  localparam int unsigned N_CODES = 16;

  // default code per slot, slot 0 in the low nibble
  localparam logic [63:0] DEFAULT_CODES = 64'hF5F1_5F5F_5F50_D515;

  // register offsets on the management port
  localparam logic [5:0] A_CODE_BASE = 6'h00;
  localparam logic [5:0] A_CTRL = 6'h10;
  localparam logic [5:0] A_DISC_MS = 6'h11;
  localparam logic [5:0] A_GUARD_MS = 6'h12;
  localparam logic [5:0] A_CMD = 6'h13;
  localparam logic [5:0] A_STATUS = 6'h14;

  // ctrl bits
  localparam int unsigned B_SELF_CLR = 0;
  localparam int unsigned B_SIMPLE = 1;
  localparam int unsigned B_TABLE = 2;
  localparam int unsigned B_AB_ONLY = 3;
  localparam int unsigned B_BLOCK_EN = 4;
  localparam int unsigned B_ACK_EN = 5;
  localparam int unsigned B_DISC_SUP = 6;
  localparam logic [6:0] CTRL_RST = 7'h43;

  // cmd bits (write-one pulses)
  localparam int unsigned B_CLR_ALARM = 0;
  localparam int unsigned B_SET_DEFAULT = 1;

  // code write data: [2:0] bit count, [7:4] value
  localparam logic [2:0] CNT_TWO = 3'h2;
  localparam logic [2:0] CNT_FOUR = 3'h4;

  typedef enum logic [3:0] {
    ST_IDLE, ST_GUARD, ST_RING, ST_IN_CONN, ST_SEIZED, ST_OUT_CONN,
    ST_DISC_HOLD, ST_DISC_WAIT, ST_BLOCKED
  } cas_state_t;
endpackage

// ---- verilog/cas_ms_timer.sv ----
/*
  cas_ms_timer: millisecond down-counter with a start pulse.
  assumes start carries the load value in ms; done pulses one cycle.
*/
`timescale 1ns/100ps
module cas_ms_timer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [11:0] load_ms,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [14:0] pre;
    logic [11:0] ms;
    logic busy;
    logic done;
  } cas_tmr_t;
  cas_tmr_t r_q, r_d;

  // prescale cycles into ms and count down
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    if (start) begin
      r_d.pre = cas_pkg::MS_LAST;
      r_d.ms = load_ms;
      r_d.busy = (load_ms != 12'h000);
      r_d.done = (load_ms == 12'h000);
    end else if (r_q.busy) begin
      if (r_q.pre == 15'h0000) begin
        r_d.pre = cas_pkg::MS_LAST;
        r_d.ms = r_q.ms - 12'h001;
        if (r_q.ms == 12'h001) begin
          r_d.busy = 1'b0;
          r_d.done = 1'b1;
        end
      end else begin
        r_d.pre = r_q.pre - 15'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign busy = r_q.busy;
  assign done = r_q.done;
endmodule

// ---- verilog/cas_ctrl.sv ----
/*
  cas_ctrl: per-channel abcd signaling controller with alarm indication
  clearing, disconnect hold and release guard timing.
  assumes rx_abcd is a stable received code, switch requests are levels
  or pulses synchronous to sys_clk, and software uses the plain reg port.
*/
// The address map and the strobed register port were chosen for this implementation.
// How it works
// - self clearing on: alarm indication drops once condition goes away
// - self clearing off: indication stays until clear-alarm command
// - conditioning and yellow follow the live condition only
// - simple off: send disconnect, wait for cpe idle, then idle
// - simple on: idle straight after the disconnect code
// - default or table mode; default reloads every code
// - two-bit entry copied into cd, four-bit whole, others rejected
// - ab-only framing ignores c and d bits of received codes
// - send idle code when idle; idle-receive code means cpe idle
// - enabled blocking code blocks channel; hook report from switch
// - ringer-on while ringing, ringer-off in silent cadence part
// - incoming off-hook answers; send connected code
// - far-end release outside ringing sends the matching disconnect code
// - seize starts outgoing call; ack sent only if enabled
// - dial make and break codes recognised while dialing
// - answered code on far-end answer; cpe disconnect ends call
// - disconnect held for programmed time, cpe reconnect ignored
// - release guard after idle ignores cpe off-hook and ring requests
`timescale 1ns/100ps
module cas_ctrl (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [3:0] rx_abcd,
  input wire logic alarm_cond,
  input wire logic block_offhook_sel,
  input wire logic sw_ring_req,
  input wire logic sw_ring_cadence_on,
  input wire logic sw_answer,
  input wire logic sw_release,
  output logic [3:0] tx_abcd,
  output logic alarm_ind,
  output logic line_cond,
  output logic yellow_tx,
  output logic sw_offhook,
  output logic dial_make,
  output logic dial_break,
  output logic cpe_disc
);
  // whole block state, registered once per clock
  typedef struct packed {
    logic [63:0] codes;
    logic [6:0] ctrl;
    logic [11:0] disc_ms;
    logic [11:0] guard_ms;
    cas_pkg::cas_state_t st;
    logic outgoing;
    logic [3:0] tx;
    logic alarm;
    logic cond;
    logic offhook;
    logic make;
    logic brk;
    logic cdisc;
    logic [15:0] rdata;
  } cas_reg_t;
  cas_reg_t r_q, r_d;

  // hold and guard timer hookup
  logic tmr_start;
  logic [11:0] tmr_load;
  logic tmr_busy;
  logic tmr_done;

  // code of one slot
  function automatic logic [3:0] slot(input logic [63:0] c, input logic [3:0] i);
    slot = c[{i, 2'b00} +: 4];
  endfunction

  // exact match on active bits only
  function automatic logic hit(input logic [63:0] c, input logic [3:0] i,
                               input logic [3:0] rx, input logic ab_only);
    logic [3:0] m;
    m = ab_only ? 4'hC : 4'hF;
    hit = ((slot(c, i) ^ rx) & m) == 4'h0;
  endfunction

  // true for the sixteen code table slots, shared by write and read decode
  function automatic logic is_code(input logic [5:0] a);
    is_code = (a[5:4] == cas_pkg::A_CODE_BASE[5:4]);
  endfunction

  // one shared timer: disconnect hold first, then release guard
  cas_ms_timer u_tmr (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(tmr_start),
    .load_ms(tmr_load),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // call state, codes, alarm and register port
  always_comb begin
    logic ab;
    logic [3:0] v;
    logic [3:0] widx;
    ab = 1'b0;
    v = 4'h0;
    widx = 4'h0;
    r_d = r_q;
    tmr_start = 1'b0;
    tmr_load = r_q.disc_ms;
    ab = r_q.ctrl[cas_pkg::B_AB_ONLY];
    widx = reg_addr[3:0];
    // pulse outputs default low each cycle
    r_d.make = 1'b0;
    r_d.brk = 1'b0;
    r_d.cdisc = 1'b0;

    // register writes
    if (reg_wr) begin
      // code entry: bit count in [2:0], value in [7:4]
      if (is_code(reg_addr)) begin
        v = reg_wdata[7:4];
        if (reg_wdata[2:0] == cas_pkg::CNT_TWO) begin
          r_d.codes[{widx, 2'b00} +: 4] = {v[3:2], v[3:2]};
        end else if (reg_wdata[2:0] == cas_pkg::CNT_FOUR) begin
          r_d.codes[{widx, 2'b00} +: 4] = v;
        end
      end else if (reg_addr == cas_pkg::A_CTRL) begin
        // mode change; default mode reloads the table
        r_d.ctrl = reg_wdata[6:0];
        if (!reg_wdata[cas_pkg::B_TABLE]) begin
          r_d.codes = cas_pkg::DEFAULT_CODES;
        end
      end else if (reg_addr == cas_pkg::A_DISC_MS) begin
        // out-of-range hold times are refused
        if (reg_wdata[11:0] <= 12'(cas_pkg::DISC_MS_MAX)) begin
          r_d.disc_ms = reg_wdata[11:0];
        end
      end else if (reg_addr == cas_pkg::A_GUARD_MS) begin
        // out-of-range guard times are refused
        if (reg_wdata[11:0] <= 12'(cas_pkg::GUARD_MS_MAX)) begin
          r_d.guard_ms = reg_wdata[11:0];
        end
      end else if (reg_addr == cas_pkg::A_CMD) begin
        // write-one command pulses
        if (reg_wdata[cas_pkg::B_SET_DEFAULT]) begin
          r_d.codes = cas_pkg::DEFAULT_CODES;
          r_d.ctrl[cas_pkg::B_TABLE] = 1'b0;
        end
        if (reg_wdata[cas_pkg::B_CLR_ALARM]) begin
          r_d.alarm = 1'b0;
        end
      end
    end

    // alarm indication latches while self-clearing is off; conditioning tracks the condition
    r_d.cond = alarm_cond;
    if (alarm_cond) begin
      r_d.alarm = 1'b1;
    end else if (r_q.ctrl[cas_pkg::B_SELF_CLR]) begin
      r_d.alarm = 1'b0;
    end

    // call state machine
    unique case (r_q.st)
      // idle: wait for blocking, seize or a ring request
      cas_pkg::ST_IDLE: begin
        r_d.tx = slot(r_q.codes, cas_pkg::C_IDLE_TX);
        r_d.offhook = 1'b0;
        if (r_q.ctrl[cas_pkg::B_BLOCK_EN] &&
            hit(r_q.codes, cas_pkg::C_BLOCK_RX, rx_abcd, ab)) begin
          r_d.st = cas_pkg::ST_BLOCKED;
        end else if (hit(r_q.codes, cas_pkg::C_SEIZE_RX, rx_abcd, ab)) begin
          r_d.st = cas_pkg::ST_SEIZED;
          r_d.outgoing = 1'b1;
          r_d.offhook = 1'b1;
        end else if (sw_ring_req) begin
          r_d.st = cas_pkg::ST_RING;
          r_d.outgoing = 1'b0;
        end
      end

      // release guard: idle code out, requests ignored
      cas_pkg::ST_GUARD: begin
        r_d.tx = slot(r_q.codes, cas_pkg::C_IDLE_TX);
        if (!tmr_busy) begin
          r_d.st = cas_pkg::ST_IDLE;
        end
      end

      // blocked: no calls, hook report from the switch position
      cas_pkg::ST_BLOCKED: begin
        r_d.tx = slot(r_q.codes, cas_pkg::C_IDLE_TX);
        r_d.offhook = block_offhook_sel;
        if (!r_q.ctrl[cas_pkg::B_BLOCK_EN] ||
            hit(r_q.codes, cas_pkg::C_IDLE_RX, rx_abcd, ab)) begin
          r_d.st = cas_pkg::ST_IDLE;
          r_d.offhook = 1'b0;
        end
      end

      // ringing: cadence picks the ringer code
      cas_pkg::ST_RING: begin
        r_d.tx = sw_ring_cadence_on ? slot(r_q.codes, cas_pkg::C_RING_ON_TX)
                                    : slot(r_q.codes, cas_pkg::C_RING_OFF_TX);
        if (hit(r_q.codes, cas_pkg::C_IN_OFFHK_RX, rx_abcd, ab)) begin
          r_d.st = cas_pkg::ST_IN_CONN;
          r_d.offhook = 1'b1;
        end else if (sw_release) begin
          r_d.st = cas_pkg::ST_IDLE;
        end
      end

      // incoming call answered and connected
      cas_pkg::ST_IN_CONN: begin
        r_d.tx = slot(r_q.codes, cas_pkg::C_IN_CONN_TX);
        if (sw_release) begin
          r_d.st = cas_pkg::ST_DISC_HOLD;
          r_d.tx = slot(r_q.codes, cas_pkg::C_IN_FDISC_TX);
          tmr_start = 1'b1;
        end else if (hit(r_q.codes, cas_pkg::C_IN_CDISC_RX, rx_abcd, ab)) begin
          r_d.cdisc = 1'b1;
          r_d.offhook = 1'b0;
          r_d.st = cas_pkg::ST_GUARD;
          tmr_start = 1'b1;
          tmr_load = r_q.guard_ms;
        end
      end

      // seized: dialing until answer, release or abandon
      cas_pkg::ST_SEIZED: begin
        r_d.tx = r_q.ctrl[cas_pkg::B_ACK_EN] ? slot(r_q.codes, cas_pkg::C_SEIZE_ACK_TX)
                                             : slot(r_q.codes, cas_pkg::C_IDLE_TX);
        r_d.make = hit(r_q.codes, cas_pkg::C_DIAL_MAKE_RX, rx_abcd, ab);
        r_d.brk = hit(r_q.codes, cas_pkg::C_DIAL_BRK_RX, rx_abcd, ab);
        if (sw_answer) begin
          r_d.st = cas_pkg::ST_OUT_CONN;
        end else if (sw_release) begin
          r_d.st = cas_pkg::ST_DISC_HOLD;
          r_d.tx = slot(r_q.codes, cas_pkg::C_OUT_FDISC_TX);
          tmr_start = 1'b1;
        end else if (hit(r_q.codes, cas_pkg::C_IDLE_RX, rx_abcd, ab)) begin
          r_d.st = cas_pkg::ST_GUARD;
          r_d.offhook = 1'b0;
          tmr_start = 1'b1;
          tmr_load = r_q.guard_ms;
        end
      end

      // outgoing call answered by the far end
      cas_pkg::ST_OUT_CONN: begin
        r_d.tx = slot(r_q.codes, cas_pkg::C_ANSWERED_TX);
        if (sw_release) begin
          r_d.st = cas_pkg::ST_DISC_HOLD;
          r_d.tx = slot(r_q.codes, cas_pkg::C_OUT_FDISC_TX);
          tmr_start = 1'b1;
        end else if (hit(r_q.codes, cas_pkg::C_OUT_CDISC_RX, rx_abcd, ab)) begin
          r_d.cdisc = 1'b1;
          r_d.offhook = 1'b0;
          r_d.st = cas_pkg::ST_GUARD;
          tmr_start = 1'b1;
          tmr_load = r_q.guard_ms;
        end
      end

      // far-end disconnect: hold the code while the timer runs
      cas_pkg::ST_DISC_HOLD: begin
        // disconnect code holds; cpe codes ignored meanwhile
        if (!r_q.ctrl[cas_pkg::B_DISC_SUP] || tmr_done) begin
          if (r_q.ctrl[cas_pkg::B_SIMPLE]) begin
            r_d.st = cas_pkg::ST_GUARD;
            r_d.offhook = 1'b0;
            tmr_start = 1'b1;
            tmr_load = r_q.guard_ms;
          end else begin
            r_d.st = cas_pkg::ST_DISC_WAIT;
          end
        end
      end

      // full tear-down: wait for the cpe to go idle
      cas_pkg::ST_DISC_WAIT: begin
        if (hit(r_q.codes, cas_pkg::C_IDLE_RX, rx_abcd, ab)) begin
          r_d.st = cas_pkg::ST_GUARD;
          r_d.offhook = 1'b0;
          tmr_start = 1'b1;
          tmr_load = r_q.guard_ms;
        end
      end

      // unused state codes fall back to idle
      default: begin
        r_d.st = cas_pkg::ST_IDLE;
      end
    endcase

    // read data one cycle after the strobe
    r_d.rdata = 16'h0000;
    if (reg_rd) begin
      if (is_code(reg_addr)) begin
        r_d.rdata = {12'h000, slot(r_q.codes, widx)};
      end else if (reg_addr == cas_pkg::A_CTRL) begin
        r_d.rdata = {9'h000, r_q.ctrl};
      end else if (reg_addr == cas_pkg::A_DISC_MS) begin
        r_d.rdata = {4'h0, r_q.disc_ms};
      end else if (reg_addr == cas_pkg::A_GUARD_MS) begin
        r_d.rdata = {4'h0, r_q.guard_ms};
      end else if (reg_addr == cas_pkg::A_STATUS) begin
        // hook, direction, conditioning, alarm, call state
        r_d.rdata = {5'h00, r_q.offhook, r_q.outgoing, r_q.cond, r_q.alarm,
                     3'h0, 4'(r_q.st)};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    // reset loads default codes, control and times
    if (sys_rst) begin
      r_q <= '{codes: cas_pkg::DEFAULT_CODES, ctrl: cas_pkg::CTRL_RST,
               disc_ms: cas_pkg::DISC_MS_RST, guard_ms: cas_pkg::GUARD_MS_RST,
               st: cas_pkg::ST_IDLE, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = r_q.rdata;
  assign tx_abcd = r_q.tx;
  assign alarm_ind = r_q.alarm;
  // conditioning and yellow both track the live condition
  assign line_cond = r_q.cond;
  assign yellow_tx = r_q.cond;
  assign sw_offhook = r_q.offhook;
  assign dial_make = r_q.make;
  assign dial_break = r_q.brk;
  assign cpe_disc = r_q.cdisc;
endmodule

// ---- dv/cas_cpe_model.sv ----
/* cas_cpe: far-end equipment model sending abcd codes.
   assumes the bench names the code to send on want. */
`timescale 1ns/100ps
module cas_cpe (
  input wire logic sys_clk,
  input wire logic [3:0] want,
  input wire logic slow,
  output logic [3:0] rx_abcd
);
  logic [3:0] d1;
  logic [3:0] d2;
  logic [3:0] d3;
  // exact codes only, one or three cycles late
  always_ff @(posedge sys_clk) begin
    d1 <= want;
    d2 <= d1;
    d3 <= d2;
  end
  assign rx_abcd = slow ? d3 : d1;
endmodule

// ---- dv/cas_ctrl_properties.sv ----
/* cas_ctrl_chk: port checker for cas_ctrl.
   assumes sys_clk and a sync active high sys_rst. */
`timescale 1ns/100ps
module cas_ctrl_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic alarm_cond,
  input wire logic alarm_ind,
  input wire logic line_cond,
  input wire logic yellow_tx,
  input wire logic cpe_disc,
  input wire logic dial_make,
  input wire logic dial_break
);
  logic self_q;
  // mirror of the self-clearing bit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      self_q <= cas_pkg::CTRL_RST[cas_pkg::B_SELF_CLR];
    end else if (reg_wr && reg_addr == cas_pkg::A_CTRL) begin
      self_q <= reg_wdata[cas_pkg::B_SELF_CLR];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  cond_follow_a: assert property (line_cond == $past(alarm_cond))
    else $error("line conditioning does not follow alarm");
  yellow_same_a: assert property (yellow_tx == line_cond)
    else $error("yellow differs from conditioning");
  alarm_set_a: assert property (alarm_cond ##1 alarm_cond |-> alarm_ind)
    else $error("alarm indication not set");
  alarm_drop_a: assert property ((!alarm_cond && self_q) [*2] |-> !alarm_ind)
    else $error("alarm indication not self cleared");
  alarm_hold_a: assert property (!self_q && alarm_ind && !reg_wr |=> alarm_ind)
    else $error("alarm indication dropped without command");
  disc_pulse_a: assert property (cpe_disc |=> !cpe_disc)
    else $error("disconnect pulse too long");
  dial_excl_a: assert property (!(dial_make && dial_break))
    else $error("make and break together");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
endmodule
bind cas_ctrl cas_ctrl_chk i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .alarm_cond(alarm_cond), .alarm_ind(alarm_ind),
  .line_cond(line_cond), .yellow_tx(yellow_tx), .cpe_disc(cpe_disc),
  .dial_make(dial_make), .dial_break(dial_break));

// ---- dv/cas_ctrl_test.sv ----
/* cas_ctrl_test: self-checking bench for cas_ctrl.
   assumes the cpe model and bound checker are compiled alongside. */
`timescale 1ns/100ps
module cas_ctrl_test;
  localparam logic [63:0] TBL = 64'h0B58_7A64_FE3D_C291;
  logic sys_clk = 0;
  logic sys_rst = 1;
  logic [5:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [15:0] reg_rdata;
  logic [3:0] rx_abcd;
  logic [3:0] want = 4'h1;
  logic slow = 0;
  logic alarm_cond = 0;
  logic block_offhook_sel = 0;
  logic sw_ring_req = 0;
  logic sw_ring_cadence_on = 0;
  logic sw_answer = 0;
  logic sw_release = 0;
  logic [3:0] tx_abcd;
  logic alarm_ind, line_cond, yellow_tx, sw_offhook, dial_make, dial_break, cpe_disc;
  logic [15:0] seed = 16'h0001;
  int bad_count = 0;
  int n_compared = 0;
  int n;
  always #20 sys_clk = ~sys_clk;
  cas_ctrl i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_abcd(rx_abcd), .alarm_cond(alarm_cond), .block_offhook_sel(block_offhook_sel),
    .sw_ring_req(sw_ring_req), .sw_ring_cadence_on(sw_ring_cadence_on),
    .sw_answer(sw_answer), .sw_release(sw_release), .tx_abcd(tx_abcd),
    .alarm_ind(alarm_ind), .line_cond(line_cond), .yellow_tx(yellow_tx),
    .sw_offhook(sw_offhook), .dial_make(dial_make), .dial_break(dial_break),
    .cpe_disc(cpe_disc));
  cas_cpe i_cpe (.sys_clk(sys_clk), .want(want), .slow(slow), .rx_abcd(rx_abcd));
  function automatic logic [3:0] tb(input int s);
    return TBL[s*4 +: 4];
  endfunction
  function automatic logic [3:0] dup(input logic [1:0] ab);
    return {ab, ab};
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic wait_tx(input logic [3:0] v, input int lim);
    int k;
    k = 0;
    #1; // never sample in the launching time step
    while (tx_abcd !== v && k < lim) begin
      step(1);
      k++;
    end
    chk(16'(tx_abcd), 16'(v));
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog sized above the two millisecond timer runs
  initial begin
    repeat (90000) @(posedge sys_clk);
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    step(2);
    chk(16'(tx_abcd), 16'(cas_pkg::DEFAULT_CODES[3:0]));
    rd_chk(cas_pkg::A_CTRL, 16'h0043);
    wr(cas_pkg::A_DISC_MS, 16'h0FA1);
    rd_chk(cas_pkg::A_DISC_MS, 16'h03E8);
    rd_chk(6'h3F, 16'h0000);
    rd_chk(cas_pkg::A_STATUS, 16'h0000);
    $display("test regs done");
    wr(cas_pkg::A_CTRL, 16'h0007);
    wr(6'h00, 16'h00C4);
    wait_tx(4'hC, 4);
    wr(6'h00, 16'h0082);
    wait_tx(dup(2'b10), 4);
    wr(6'h00, 16'h0033);
    step(3);
    chk(16'(tx_abcd), 16'(dup(2'b10)));
    wr(cas_pkg::A_CMD, 16'h0002);
    wait_tx(cas_pkg::DEFAULT_CODES[3:0], 4);
    wr(cas_pkg::A_CTRL, 16'h0007);
    for (int i = 0; i < 16; i++) wr(6'(i), {8'h00, tb(i), 1'b0, cas_pkg::CNT_FOUR});
    wait_tx(tb(0), 4);
    @(posedge sys_clk);
    want <= 4'hE;
    step(6);
    chk(16'(tx_abcd), 16'(tb(0)));
    chk(16'(sw_offhook), 16'h0000);
    want <= tb(1);
    $display("test codes done");
    // ab-only framing: codes with c and d flipped still match
    wr(cas_pkg::A_CTRL, 16'h000F);
    @(posedge sys_clk);
    want <= tb(9) ^ 4'h3;
    step(4);
    chk(16'(sw_offhook), 16'h0001);
    want <= tb(1) ^ 4'h3;
    step(6);
    chk(16'(sw_offhook), 16'h0000);
    $display("test framing done");
    // outgoing calls without and with seize acknowledgement
    for (int a = 0; a < 2; a++) begin
      wr(cas_pkg::A_CTRL, a ? 16'h0027 : 16'h0007);
      @(posedge sys_clk);
      want <= tb(9);
      step(4);
      chk(16'(sw_offhook), 16'h0001);
      chk(16'(tx_abcd), 16'(a ? tb(10) : tb(0)));
      for (int i = 0; i < 8; i++) begin
        seed = lfsr(seed);
        @(posedge sys_clk);
        want <= seed[0] ? tb(11) : tb(12);
        slow <= seed[1];
        step(6);
        chk(16'(dial_make), 16'(seed[0]));
        chk(16'(dial_break), 16'(!seed[0]));
      end
      @(posedge sys_clk);
      sw_answer <= 1'b1;
      @(posedge sys_clk);
      sw_answer <= 1'b0;
      wait_tx(tb(13), 4);
      want <= tb(14);
      n = 0;
      while (cpe_disc !== 1'b1 && n < 10) begin
        step(1);
        n++;
      end
      chk(16'(cpe_disc), 16'h0001);
      @(posedge sys_clk);
      want <= tb(1);
      slow <= 1'b0;
      wait_tx(tb(0), 8);
    end
    $display("test outgoing done");
    // incoming calls, full then simplified tear-down
    for (int m = 0; m < 2; m++) begin
      wr(cas_pkg::A_CTRL, m ? 16'h0007 : 16'h0005);
      @(posedge sys_clk);
      sw_ring_req <= 1'b1;
      sw_ring_cadence_on <= 1'b1;
      wait_tx(tb(3), 4);
      sw_ring_cadence_on <= 1'b0;
      wait_tx(tb(4), 4);
      want <= tb(5);
      sw_ring_req <= 1'b0;
      wait_tx(tb(6), 6);
      @(posedge sys_clk);
      sw_release <= 1'b1;
      @(posedge sys_clk);
      sw_release <= 1'b0;
      if (m) begin
        wait_tx(tb(0), 6);
      end else begin
        step(20);
        chk(16'(tx_abcd), 16'(tb(7)));
      end
      want <= tb(1);
      wait_tx(tb(0), 8);
    end
    $display("test incoming done");
    wr(cas_pkg::A_CTRL, 16'h0015);
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      block_offhook_sel <= s[0];
      want <= tb(2);
      step(6);
      chk(16'(sw_offhook), 16'(s));
      want <= tb(1);
      step(6);
    end
    $display("test blocking done");
    // alarms with self-clearing on, then off
    for (int s = 0; s < 2; s++) begin
      wr(cas_pkg::A_CTRL, s ? 16'h0004 : 16'h0005);
      @(posedge sys_clk);
      alarm_cond <= 1'b1;
      step(3);
      chk(16'(alarm_ind), 16'h0001);
      chk(16'(yellow_tx), 16'h0001);
      rd_chk(cas_pkg::A_STATUS, 16'h0180);
      alarm_cond <= 1'b0;
      step(3);
      chk(16'(line_cond), 16'h0000);
      chk(16'(alarm_ind), 16'(s));
      wr(cas_pkg::A_CMD, 16'h0001);
      step(2);
      chk(16'(alarm_ind), 16'h0000);
    end
    $display("test alarms done");
    // disconnect hold then release guard, one millisecond each
    wr(cas_pkg::A_CTRL, 16'h0047);
    wr(cas_pkg::A_DISC_MS, 16'h0001);
    wr(cas_pkg::A_GUARD_MS, 16'h0001);
    @(posedge sys_clk);
    sw_ring_req <= 1'b1;
    sw_ring_cadence_on <= 1'b1;
    want <= tb(5);
    wait_tx(tb(6), 8);
    sw_ring_req <= 1'b0;
    sw_release <= 1'b1;
    @(posedge sys_clk);
    sw_release <= 1'b0;
    step(20000);
    chk(16'(tx_abcd), 16'(tb(7)));
    wait_tx(tb(0), 10000);
    want <= tb(9);
    sw_ring_req <= 1'b1;
    step(10000);
    chk(16'(tx_abcd), 16'(tb(0)));
    chk(16'(sw_offhook), 16'h0000);
    sw_ring_req <= 1'b0;
    n = 0;
    while (sw_offhook !== 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
    chk(16'(sw_offhook), 16'h0001);
    chk(16'(n > 10000), 16'h0001);
    $display("test guard done");
    stop_test;
  end
endmodule
